// File: hdl/css_consts.svh
// constants for the clocked serial slave channel
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_ADDR_W 4
`define CSS_OFF_CONFIG 4'h0
`define CSS_OFF_START 4'h1
`define CSS_OFF_STOP 4'h2
`define CSS_OFF_OUTEN 4'h3
`define CSS_OFF_DATA 4'h4
`define CSS_OFF_STATUS 4'h5
`define CSS_OFF_IRQSTAT 4'h6
`define CSS_OFF_IRQMASK 4'h7
`define CSS_CFG_TXRX 0
`define CSS_CFG_DAP 1
`define CSS_CFG_CKP 2
`define CSS_CFG_LSB 3
`define CSS_CFG_LEN7 4
`define CSS_CFG_IRQSRC 5
`define CSS_CFG_RESET 8'h00
`define CSS_ST_ENABLED 0
`define CSS_ST_BFF 1
`define CSS_ST_OVF 2
`define CSS_ST_BUSY 3
`define CSS_IRQ_XFER 0
`define CSS_IRQ_OVF 1
`define CSS_SYNC_STAGES 3
`endif

// File: hdl/css_pkg.sv
// types for the clocked serial slave channel
`default_nettype none
package css_pkg;
   typedef logic [7:0] css_byte_t;
   typedef logic [3:0] css_addr_t;
   typedef enum logic [1:0] {CSS_IDLE, CSS_SHIFT} css_state_e;
endpackage
`default_nettype wire

// File: hdl/css_pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
`include "css_consts.svh"
module css_pin_sync (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pinIn,
   output logic level
);
   typedef struct packed {
      logic [`CSS_SYNC_STAGES-1:0] stage;
      logic lvl;
   } css_sync_s;
   css_sync_s st_r;
   css_sync_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.stage = {st_r.stage[1:0], pinIn};
      // stage 0 feeds only stage 1; stages 1 and 2 must agree
      if (st_r.stage[1] == st_r.stage[2]) begin
         st_nxt.lvl = st_r.stage[2];
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign level = st_r.lvl;
endmodule
`default_nettype wire

// File: hdl/css_slave.sv
// one channel of a clocked serial slave, receive-only or transmit/receive
// Behaviour
// - receive-only mode raises only the transfer-end and overrun interrupts.
// - transmit/receive offers transfer-end or buffer-empty interrupt source.
// - overrun is the only error flagged.
// - seven or eight bit words, MSB or LSB first.
// - serial clock must not exceed one sixth of the operation clock.
// - receive: phase 0 samples from clock start, 1 half period earlier.
// - transmit/receive: phase moves output and input together.
// - polarity 0 uses clock as is, 1 inverted.
// - receive-only ignores the output enable; data output stays idle.
// - first transmit word is loaded before the master starts clocking.
// - a data write while the buffer is full replaces the pending word.
`timescale 1ns/1ps
`default_nettype none
`include "css_consts.svh"
module css_slave (
   input wire logic ref_clk,
   input wire logic reset,
   input wire css_pkg::css_addr_t regAddr,
   input wire css_pkg::css_byte_t regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output css_pkg::css_byte_t regRdData,
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOutEn,
   output logic transferIrq
);
   import css_pkg::*;

   typedef struct packed {
      css_byte_t cfg;
      logic enabled;
      logic outEn;
      css_byte_t txBuf;
      logic bff;
      logic txLoaded;
      css_byte_t shiftReg;
      logic [3:0] bitCnt;
      css_state_e state;
      css_byte_t rxData;
      logic rxUnread;
      logic ovf;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic sckPrev;
      logic sdo;
      logic sdoEn;
      logic irq;
      css_byte_t rdData;
   } css_slave_s;

   css_slave_s s_r;
   css_slave_s s_nxt;
   logic sckLvl;
   logic sdiLvl;

   // both pins resampled on ref_clk; edges valid only at up to ref_clk/6
   css_pin_sync u_sck (
      .ref_clk(ref_clk),
      .reset(reset),
      .pinIn(serialClockIn),
      .level(sckLvl)
   );
   css_pin_sync u_sdi (
      .ref_clk(ref_clk),
      .reset(reset),
      .pinIn(serialDataIn),
      .level(sdiLvl)
   );

   always_comb begin
      logic txrx;
      logic dap;
      logic lsb;
      logic len7;
      logic sck;
      logic rise;
      logic fall;
      logic capEdge;
      logic shiftEdge;
      logic [3:0] wlen;
      logic wordDone;
      logic bufEmptyEv;
      logic xferEv;
      logic ovfEv;
      css_byte_t rxWord;
      css_byte_t nextSh;
      logic outBit;
      s_nxt = s_r;
      txrx = s_r.cfg[`CSS_CFG_TXRX];
      dap = s_r.cfg[`CSS_CFG_DAP];
      lsb = s_r.cfg[`CSS_CFG_LSB];
      len7 = s_r.cfg[`CSS_CFG_LEN7];
      wlen = len7 ? 4'h7 : 4'h8;
      sck = sckLvl ^ s_r.cfg[`CSS_CFG_CKP];
      s_nxt.sckPrev = sck;
      rise = sck & ~s_r.sckPrev;
      fall = ~sck & s_r.sckPrev;
      // phase 0: shift out on falling, capture on rising; phase 1 one half earlier
      capEdge = dap ? fall : rise;
      shiftEdge = dap ? rise : fall;
      wordDone = 1'b0;
      bufEmptyEv = 1'b0;
      ovfEv = 1'b0;
      rxWord = 8'h00;
      nextSh = s_r.shiftReg;
      outBit = 1'b0;
      // register writes
      if (regWrStb) begin
         case (regAddr)
            `CSS_OFF_CONFIG: s_nxt.cfg = regWrData;
            `CSS_OFF_START: begin
               if (regWrData[0]) begin
                  s_nxt.enabled = 1'b1;
                  s_nxt.state = CSS_IDLE;
                  s_nxt.bitCnt = 4'h0;
                  s_nxt.txLoaded = 1'b0;
               end
            end
            `CSS_OFF_STOP: begin
               if (regWrData[0]) begin
                  s_nxt.enabled = 1'b0;
               end
            end
            `CSS_OFF_OUTEN: s_nxt.outEn = regWrData[0];
            `CSS_OFF_DATA: begin
               s_nxt.txBuf = regWrData;
               s_nxt.bff = 1'b1;
            end
            `CSS_OFF_IRQMASK: s_nxt.irqMask = regWrData[1:0];
            default: begin
            end
         endcase
      end
      // reading the data register consumes the received word
      if (regRdStb && regAddr == `CSS_OFF_DATA) begin
         s_nxt.rxUnread = 1'b0;
      end
      if (regWrStb && regAddr == `CSS_OFF_STATUS && regWrData[`CSS_ST_OVF]) begin
         s_nxt.ovf = 1'b0;
      end
      if (regWrStb && regAddr == `CSS_OFF_IRQSTAT) begin
         s_nxt.irqStat = s_r.irqStat & ~regWrData[1:0];
      end
      // shift engine, clocked only by edges from the master
      if (s_r.enabled) begin
         case (s_r.state)
            CSS_IDLE: begin
               if (capEdge || (txrx && dap == 1'b0 && shiftEdge)) begin
                  s_nxt.state = CSS_SHIFT;
               end
               if (txrx && s_r.bff && !s_r.txLoaded && s_r.bitCnt == 4'h0) begin
                  // preload first word so its first bit is out before any edge
                  // only an empty shifter is loaded; later writes wait in the buffer
                  s_nxt.shiftReg = s_r.txBuf;
                  s_nxt.txLoaded = 1'b1;
                  s_nxt.bff = regWrStb && regAddr == `CSS_OFF_DATA;
                  bufEmptyEv = 1'b1;
               end
               if (capEdge) begin
                  s_nxt.state = CSS_SHIFT;
               end
            end
            CSS_SHIFT: begin
            end
            default: s_nxt.state = CSS_IDLE;
         endcase
         if (capEdge) begin
            nextSh = lsb ? {sdiLvl, s_r.shiftReg[7:1]} : {s_r.shiftReg[6:0], sdiLvl};
            s_nxt.shiftReg = nextSh;
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
            if (s_r.bitCnt + 4'h1 == wlen) begin
               wordDone = 1'b1;
               s_nxt.bitCnt = 4'h0;
               s_nxt.state = CSS_IDLE;
            end
         end
      end
      if (wordDone) begin
         if (lsb) begin
            rxWord = len7 ? {1'b0, nextSh[7:1]} : nextSh;
         end else begin
            rxWord = len7 ? {1'b0, nextSh[6:0]} : nextSh;
         end
         s_nxt.rxData = rxWord;
         s_nxt.rxUnread = 1'b1;
         if (s_r.rxUnread) begin
            ovfEv = 1'b1;
         end
         if (txrx && s_r.bff) begin
            s_nxt.shiftReg = s_r.txBuf;
            s_nxt.bff = regWrStb && regAddr == `CSS_OFF_DATA;
            bufEmptyEv = 1'b1;
         end else begin
            s_nxt.txLoaded = 1'b0;
         end
      end
      // output bit from current shift register
      outBit = lsb ? s_r.shiftReg[0] : (len7 ? s_r.shiftReg[6] : s_r.shiftReg[7]);
      if (txrx && s_r.enabled && shiftEdge && !capEdge && s_r.state == CSS_SHIFT) begin
         outBit = lsb ? s_r.shiftReg[0] : (len7 ? s_r.shiftReg[6] : s_r.shiftReg[7]);
      end
      if (ovfEv) begin
         s_nxt.ovf = 1'b1; // set wins over clear
      end
      // interrupt source: receive-only forces transfer end
      xferEv = (txrx && s_r.cfg[`CSS_CFG_IRQSRC]) ? bufEmptyEv : wordDone;
      if (xferEv) begin
         s_nxt.irqStat[`CSS_IRQ_XFER] = 1'b1;
      end
      if (ovfEv) begin
         s_nxt.irqStat[`CSS_IRQ_OVF] = 1'b1;
      end
      // output pin only in transmit/receive with enable set
      s_nxt.sdoEn = txrx && s_r.outEn && s_r.enabled;
      s_nxt.sdo = s_nxt.sdoEn ? outBit : 1'b1;
      s_nxt.irq = |(s_nxt.irqStat & s_r.irqMask);
      s_nxt.rdData = 8'h00;
      if (regRdStb) begin
         case (regAddr)
            `CSS_OFF_CONFIG: s_nxt.rdData = s_r.cfg;
            `CSS_OFF_OUTEN: s_nxt.rdData = {7'h00, s_r.outEn};
            `CSS_OFF_DATA: s_nxt.rdData = s_r.rxData;
            `CSS_OFF_STATUS: s_nxt.rdData = {4'h0, s_r.state == CSS_SHIFT, s_r.ovf, s_r.bff,
               s_r.enabled};
            `CSS_OFF_IRQSTAT: s_nxt.rdData = {6'h00, s_r.irqStat};
            `CSS_OFF_IRQMASK: s_nxt.rdData = {6'h00, s_r.irqMask};
            default: s_nxt.rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
         s_r.cfg <= `CSS_CFG_RESET;
         s_r.sdo <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regRdData = s_r.rdData;
   assign serialDataOut = s_r.sdo;
   assign serialDataOutEn = s_r.sdoEn;
   assign transferIrq = s_r.irq;
endmodule
`default_nettype wire

// File: bench/css_master_model.sv
// serial master model driving clock and data into the slave channel
`timescale 1ns/1ps
`default_nettype none
module css_master_model (
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sck = 1'b1;
      mosi = 1'b1;
   end
   // clock stands at its idle level between frames
   task automatic park(input logic cpol);
      sck = ~cpol;
   endtask
   // 125 ns period, well under a sixth of the slave clock
   task automatic frame(input logic [7:0] c, input logic [7:0] seq, output logic [7:0] got);
      int n = c[4] ? 7 : 8;
      got = 8'h00;
      for (int i = 0; i < n; i++) begin
         mosi = seq[i];
         sck = c[1] ^ c[2];
         #62.5;
         sck = ~c[1] ^ c[2]; // capture edge
         got[i] = miso;
         #62.5;
      end
      sck = ~c[2];
      mosi = ~mosi;
   endtask
endmodule
`default_nettype wire

// File: bench/css_slave_assertions.sv
// port checker for the clocked serial slave channel
`timescale 1ns/1ps
`default_nettype none
module css_slave_assertions (
   input wire logic ref_clk,
   input wire logic reset,
   input wire css_pkg::css_addr_t regAddr,
   input wire css_pkg::css_byte_t regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire css_pkg::css_byte_t regRdData,
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   input wire logic serialDataOut,
   input wire logic serialDataOutEn,
   input wire logic transferIrq
);
   import css_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [4:0] quiet_r;
   logic sckPrev_r;
   // cycles since the last serial clock change or register write
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         quiet_r <= 5'h00;
         sckPrev_r <= 1'b0;
      end else begin
         sckPrev_r <= serialClockIn;
         quiet_r <= (regWrStb || serialClockIn != sckPrev_r) ? 5'h00 :
            quiet_r + {4'h0, quiet_r != 5'h1F};
      end
   end
   read_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
      else $error("read data outside read cycle");
   unmapped_read_a: assert property (regRdStb && regAddr > 4'h7
      |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   out_idle_high_a: assert property (!serialDataOutEn |-> serialDataOut)
      else $error("data out not idle high");
   rx_no_drive_a: assert property (regWrStb && regAddr == 4'h0 && !regWrData[0]
      |-> ##2 !serialDataOutEn)
      else $error("receive mode drives output");
   stop_drop_a: assert property (regWrStb && regAddr == 4'h2 && regWrData[0]
      |-> ##2 !serialDataOutEn)
      else $error("output driven after stop");
   mask_off_quiet_a: assert property (regWrStb && regAddr == 4'h7
      && regWrData == 8'h00 |-> ##2 !transferIrq)
      else $error("irq with mask cleared");
   en_from_write_a: assert property ($rose(serialDataOutEn)
      |-> $past(regWrStb) || $past(regWrStb, 2) || $past(regWrStb, 3))
      else $error("output enable without setup");
   irq_from_cause_a: assert property ($rose(transferIrq) |-> quiet_r < 5'h10)
      else $error("irq without clock edge or write");
endmodule
bind css_slave css_slave_assertions css_slave_assertions_inst (.ref_clk(ref_clk), .reset(reset),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData(regRdData), .serialClockIn(serialClockIn), .serialDataIn(serialDataIn),
   .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn), .transferIrq(transferIrq));
`default_nettype wire

// File: bench/css_slave_tb_top.sv
// self-checking bench for the clocked serial slave channel
`timescale 1ns/1ps
`default_nettype none
module css_slave_tb_top;
   import css_pkg::*;
   typedef struct {css_byte_t cfg; css_byte_t tx; css_byte_t rx; logic [1:0] irq;} css_row_s;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   css_addr_t regAddr = 4'h0;
   css_byte_t regWrData = 8'h00;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   css_byte_t regRdData, rdv, got;
   logic sck, mosi, serialDataOut, serialDataOutEn, transferIrq;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // cfg, tx word, rx word, {irq before frame, irq after frame}
   css_row_s rows[5] = '{'{8'h00, 8'h00, 8'hA5, 2'b01}, '{8'h3E, 8'h00, 8'h5C, 2'b01},
      '{8'h0D, 8'h3C, 8'hC3, 2'b01}, '{8'h13, 8'h5A, 8'h66, 2'b01}, '{8'h21, 8'h81, 8'h7E, 2'b10}};
   always #2 ref_clk = ~ref_clk;
   css_slave css_slave_inst (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .serialClockIn(sck), .serialDataIn(mosi), .serialDataOut(serialDataOut),
      .serialDataOutEn(serialDataOutEn), .transferIrq(transferIrq));
   css_master_model css_master_model_inst (.sck(sck), .mosi(mosi), .miso(serialDataOut));
   task automatic wr(input css_addr_t a, input css_byte_t d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(input css_addr_t a);
      @(posedge ref_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      @(negedge ref_clk);
      rdv = regRdData;
   endtask
   task automatic chk(input string s, input css_byte_t e, input css_byte_t g);
      total_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", s, e, g);
         num_errors++;
      end
   endtask
   // wire order of a word for a given config
   function automatic css_byte_t ord(css_byte_t w, css_byte_t c);
      int n = c[4] ? 7 : 8;
      ord = 8'h00;
      for (int i = 0; i < n; i++)
         ord[i] = c[3] ? w[i] : w[n - 1 - i];
   endfunction
   task automatic xfer(input css_byte_t c, input css_byte_t rx);
      css_master_model_inst.frame(c, ord(rx, c), got);
      repeat (12) @(posedge ref_clk);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(4'h5);
      chk("status", 8'h00, rdv);
      rd(4'hF);
      chk("unmapped", 8'h00, rdv);
      chk("pins", 8'h01, {5'h00, transferIrq, serialDataOutEn, serialDataOut});
      $display("reset test done");
      foreach (rows[k]) begin
         css_master_model_inst.park(rows[k].cfg[2]);
         wr(4'h0, rows[k].cfg);
         wr(4'h3, 8'h01);
         wr(4'h7, 8'h03);
         if (rows[k].cfg[0])
            wr(4'h4, rows[k].tx);
         wr(4'h1, 8'h01);
         repeat (4) @(posedge ref_clk);
         chk("early irq", {7'h00, rows[k].irq[1]}, {7'h00, transferIrq});
         wr(4'h6, 8'h03);
         xfer(rows[k].cfg, rows[k].rx);
         chk("end irq", {7'h00, rows[k].irq[0]}, {7'h00, transferIrq});
         chk("drive", {7'h00, rows[k].cfg[0]}, {7'h00, serialDataOutEn});
         rd(4'h4);
         chk("rx", rows[k].rx & {~rows[k].cfg[4], 7'h7F}, rdv);
         if (rows[k].cfg[0])
            chk("tx", ord(rows[k].tx, rows[k].cfg), got);
         wr(4'h6, 8'h03);
         wr(4'h2, 8'h01);
         $display("row %0d done", k);
      end
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h01);
      xfer(8'h00, 8'h12);
      xfer(8'h00, 8'h34);
      rd(4'h5);
      chk("ovf status", 8'h05, rdv);
      rd(4'h6);
      chk("irq status", 8'h03, rdv);
      rd(4'h4);
      chk("last word", 8'h34, rdv);
      wr(4'h5, 8'h04);
      rd(4'h5);
      chk("ovf clear", 8'h01, rdv);
      wr(4'h7, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("masked", 8'h00, {7'h00, transferIrq});
      wr(4'h7, 8'h03);
      wr(4'h2, 8'h01);
      rd(4'h5);
      chk("stopped", 8'h00, rdv);
      $display("overrun test done");
      wr(4'h0, 8'h01);
      wr(4'h1, 8'h01);
      wr(4'h4, 8'h11);
      wr(4'h4, 8'h22);
      rd(4'h5);
      chk("bff", 8'h03, rdv);
      wr(4'h4, 8'h33);
      xfer(8'h01, 8'h00);
      chk("first", ord(8'h11, 8'h01), got);
      wr(4'h0, 8'h21);
      wr(4'h6, 8'h03);
      xfer(8'h21, 8'h00);
      chk("replaced", ord(8'h33, 8'h21), got);
      rd(4'h6);
      chk("irq source", 8'h02, rdv);
      wr(4'h2, 8'h01);
      $display("replace test done");
      finish_test();
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule
`default_nettype wire
